/* File: hdl/pdmmic_cfg.svh */
`ifndef PDMMIC_CFG_SVH
`define PDMMIC_CFG_SVH
// clock and timing figures
`define PDMMIC_CLK_PERIOD_NS   4
`define PDMMIC_SLEEP_FREQ_KHZ  200
`define PDMMIC_LP_FREQ_KHZ     768
`define PDMMIC_HQ_MIN_FREQ_KHZ 2000
`define PDMMIC_WAKE_MS         7
// link clock half periods longer than this mean sleep (round down)
`define PDMMIC_SLEEP_CYC  ((1000000 / `PDMMIC_SLEEP_FREQ_KHZ) / `PDMMIC_CLK_PERIOD_NS)
// periods longer than this (about 1.2 MHz) mean low-power listening
`define PDMMIC_LP_CYC     ((1000000 / 1200) / `PDMMIC_CLK_PERIOD_NS)
`define PDMMIC_WAKE_CYC   ((`PDMMIC_WAKE_MS * 1000000) / `PDMMIC_CLK_PERIOD_NS)
// modulator reset state
`define PDMMIC_INT_RST    24'h000000
`endif

/* File: hdl/pdmmic_pkg.sv */
package pdmmic_pkg;
  typedef enum logic [1:0] {PDMMIC_SLEEP, PDMMIC_WAKE, PDMMIC_RUN} pdmmic_state_t;
  // data pin as two signals
  typedef struct packed {
    logic o;
    logic oe;
  } pdmmic_pin_t;
endpackage

/* File: hdl/pdmmic_out.sv */
`timescale 1ns/1ps
`include "pdmmic_cfg.svh"
// Functional notes
// - one modulator bit per link clock period
// - left launches falling, right launches rising
// - release line during other half cycle
// - strap low right, strap high left
// - strap sampled once after power-up
// - never drive in other slot
// - ones density means positive amplitude
// - zero input gives alternating ones zeros
// - slow clock means sleep, output released
// - valid data seven ms after wake
// - low-power listening selected by clock rate
module pdmmic_out #(
  parameter int W        = 24,                  // audio sample width; the integrator is four bits wider
  parameter int WAKE_CYC = `PDMMIC_WAKE_CYC     // shorten in simulation
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 link_clk,     // clock from codec
  input  wire logic                 select_strap, // channel strap pin
  input  wire logic signed [W-1:0]  sample,       // audio input, same domain
  output pdmmic_pkg::pdmmic_pin_t   data_pin,     // data line drive
  output logic                      low_power_listening,
  output logic                      asleep
);
  localparam int SLP = `PDMMIC_SLEEP_CYC;
  localparam int LPC = `PDMMIC_LP_CYC;
  // counter width must hold the wake count and the saturated period count
  // (two half periods of sleep length plus margin); a narrower counter
  // would wrap and misjudge the link rate
  localparam int CW  = $clog2(WAKE_CYC + 2 * SLP + 3);

  // two-flop synchronisers; first stage read only by second
  logic [1:0] clk_sync_q, sel_sync_q;
  logic       clk_prev_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clk_sync_q <= 2'h0;
      sel_sync_q <= 2'h0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], link_clk};
      sel_sync_q <= {sel_sync_q[0], select_strap};
      clk_prev_q <= clk_sync_q[1];
    end
  end
  wire lclk = clk_sync_q[1];
  // edges count only once the synchroniser and edge register hold real
  // pin levels; a link clock parked high at reset release would otherwise
  // show a false rise and wake the block
  wire rise = lclk & ~clk_prev_q & strap_done_q;
  wire fall = ~lclk & clk_prev_q & strap_done_q;

  // strap catch: taken once after reset release, then frozen
  // reset stands for power-up here: there is no other moment to sample
  // a later change of the strap pin is ignored on purpose
  logic left_q, left_d, strap_done_q, strap_done_d;
  always_comb begin
    left_d       = left_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      left_d = sel_sync_q[1];
    end
  end
  logic [1:0] strap_wait_q;                       // let synchroniser fill first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_wait_q <= 2'h0;
      left_q       <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      strap_wait_q <= (strap_wait_q == 2'h3) ? strap_wait_q : strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h3) begin
        left_q       <= left_d;
        strap_done_q <= strap_done_d;
      end
    end
  end

  // clock rate monitor: cycles per period and since last edge
  logic [CW-1:0] idle_q, idle_d, per_q, per_d, cnt_q, cnt_d;
  pdmmic_pkg::pdmmic_state_t st_q, st_d;
  logic lp_q, lp_d;
  always_comb begin
    idle_d = (rise | fall) ? '0 : ((idle_q == CW'(SLP + 1)) ? idle_q : idle_q + 1'b1);
    per_d  = rise ? '0 : ((per_q == CW'(2 * SLP + 2)) ? per_q : per_q + 1'b1);
    lp_d   = lp_q;
    if (rise) begin
      lp_d = (per_q > CW'(LPC));
    end
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      pdmmic_pkg::PDMMIC_SLEEP: begin
        cnt_d = '0;
        if (rise) begin
          st_d = pdmmic_pkg::PDMMIC_WAKE;
        end
      end
      pdmmic_pkg::PDMMIC_WAKE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CW'(WAKE_CYC - 1)) begin
          st_d = pdmmic_pkg::PDMMIC_RUN;
        end
      end
      pdmmic_pkg::PDMMIC_RUN: begin
        cnt_d = '0;
      end
      default: begin
        st_d = pdmmic_pkg::PDMMIC_SLEEP;
      end
    endcase
    // clock stalled or too slow: go to sleep from anywhere
    if (idle_q >= CW'(SLP)) begin
      st_d = pdmmic_pkg::PDMMIC_SLEEP;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idle_q <= '0;
      per_q  <= '0;
      lp_q   <= 1'b0;
      cnt_q  <= '0;
      st_q   <= pdmmic_pkg::PDMMIC_SLEEP;
    end else begin
      idle_q <= idle_d;
      per_q  <= per_d;
      lp_q   <= lp_d;
      cnt_q  <= cnt_d;
      st_q   <= st_d;
    end
  end

  // error-feedback modulator, one step per link period
  // a chain of four unit-gain integrators with one-bit feedback is not
  // stable and runs away; this loop keeps one integrator so that the bit
  // density tracks the input within a bounded error over any window
  // limitation: the noise shaping is first order, so in-band noise is
  // higher than a tuned higher-order loop would give
  // the integrator has four guard bits, so full-scale input cannot wrap
  logic signed [W+3:0] i1_q, i1_d;                // integrator state
  logic                bit_q, bit_d;              // current output bit
  logic signed [W+3:0] fb;                        // fed back full scale
  always_comb begin
    fb    = bit_q ? (W+4)'(2 ** (W - 1)) : -(W+4)'(2 ** (W - 1)); // ones = positive
    i1_d  = i1_q;
    bit_d = bit_q;
    // step on the launching edge of our own slot
    if ((left_q ? fall : rise) && st_q != pdmmic_pkg::PDMMIC_SLEEP) begin
      i1_d = i1_q + (W+4)'(sample) - fb;
      // ties alternate, so a zero input toggles each period
      bit_d = (i1_d == '0) ? ~bit_q : ~i1_d[W+3];
    end
  end

  // slot gating: drive only in own half, release otherwise
  // the enable follows the detected edges, so the drive window trails the
  // pin clock by the synchroniser latency on both ends; the half period
  // is many system clocks long, so the window never overlaps the partner
  logic oe_q, oe_d;
  always_comb begin
    oe_d = oe_q;
    if (st_d != pdmmic_pkg::PDMMIC_RUN) begin
      oe_d = 1'b0;
    end else if (left_q) begin
      if (fall) oe_d = 1'b1;
      if (rise) oe_d = 1'b0;
    end else begin
      if (rise) oe_d = 1'b1;
      if (fall) oe_d = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      i1_q  <= (W+4)'(`PDMMIC_INT_RST);
      bit_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      i1_q  <= i1_d;
      bit_q <= bit_d;
      oe_q  <= oe_d;
    end
  end

  // data held only while enabled; the line does not keep the level after
  // release, so the receiver must sample it only inside this device's slot
  // low-power flag shows only in run, so a stale rate from before sleep
  // never reaches the outside
  assign data_pin.o          = bit_q;
  assign data_pin.oe         = oe_q;
  assign low_power_listening = lp_q & (st_q == pdmmic_pkg::PDMMIC_RUN);
  assign asleep              = (st_q == pdmmic_pkg::PDMMIC_SLEEP);
endmodule

/* File: sim/pdmmic_checker.sv */
`timescale 1ns/1ps
// watches slot timing of the shared data line
module pdmmic_checker #(parameter int W = 24) (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic                 link_clk,
  input wire logic                 select_strap,
  input wire logic signed [W-1:0]  sample,
  input pdmmic_pkg::pdmmic_pin_t   data_pin,
  input wire logic                 low_power_listening,
  input wire logic                 asleep
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // sync latency is 2-3 cycles, half period far longer
  a_sleep_quiet: assert property (asleep |-> !data_pin.oe) else $error("drive in sleep");
  a_right_rise: assert property ($rose(data_pin.oe) && !select_strap |-> link_clk)
    else $error("right slot wrong");
  a_left_fall: assert property ($rose(data_pin.oe) && select_strap |-> !link_clk)
    else $error("left slot wrong");
  a_right_release: assert property (data_pin.oe && !select_strap && $fell(link_clk)
    |-> ##[1:6] !data_pin.oe) else $error("right not released");
  a_left_release: assert property (data_pin.oe && select_strap && $rose(link_clk)
    |-> ##[1:6] !data_pin.oe) else $error("left not released");
  a_bit_held: assert property (data_pin.oe && $past(data_pin.oe) |-> $stable(data_pin.o))
    else $error("bit changed in slot");
  a_lp_run: assert property (asleep |-> !low_power_listening) else $error("lp in sleep");
  a_oe_stands: assert property ($rose(data_pin.oe) |-> data_pin.oe[*8]) else $error("short");
endmodule
bind pdmmic_out pdmmic_checker #(.W(W)) chk (.clock(clock), .rstn(rstn), .link_clk(link_clk),
  .select_strap(select_strap), .sample(sample), .data_pin(data_pin),
  .low_power_listening(low_power_listening), .asleep(asleep));

/* File: sim/pdmmic_codec.sv */
`timescale 1ns/1ps
// codec side: makes the link clock, counts bits taken from the line
module pdmmic_codec (
  input wire logic                 run,      // clock stands still while low
  input wire logic [19:0]          half_ps,  // half link period
  input wire logic                 slot,     // 1 left, 0 right
  input pdmmic_pkg::pdmmic_pin_t   pin,      // device drive
  output logic                     link_clk, // clock to device
  output int                       ones,     // ones captured
  output int                       bits      // bits captured
);
  logic last = 1'b0;                         // last driven level
  // no pull on the line, so a released line shows no stale bit
  wire  line = pin.oe ? pin.o : ~last;
  always @(pin) if (pin.oe) last = pin.o;
  initial begin
    link_clk = 1'b0;
    ones = 0;
    bits = 0;
    forever begin
      #(half_ps * 1ps);
      if (run && link_clk != slot) begin
        ones += line;
        bits++;
      end
      if (run) link_clk = ~link_clk;
    end
  end
endmodule

/* File: sim/pdmmic_out_tb.sv */
`timescale 1ns/1ps
module pdmmic_out_tb;
  logic clock = 0, rstn = 0, strap = 0, run = 0, link_clk, lp, asleep;
  logic signed [23:0]       sample = '0;  // audio in
  logic [19:0]              half_ps = 20'd62500;
  pdmmic_pkg::pdmmic_pin_t  pin;
  int ones, bits, fails = 0, total_checks = 0, cyc = 0, o0, b0, n, want, tol;
  initial forever #2 clock = ~clock;
  pdmmic_out #(.W(24), .WAKE_CYC(100)) dut (.clock(clock), .rstn(rstn), .link_clk(link_clk),
    .select_strap(strap), .sample(sample), .data_pin(pin), .low_power_listening(lp),
    .asleep(asleep));
  pdmmic_codec codec (.run(run), .half_ps(half_ps), .slot(strap), .pin(pin),
    .link_clk(link_clk), .ones(ones), .bits(bits));
  task cmp(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, run needs about 51k cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      test_done;
    end
  end
  // ones density model; zero input must alternate, so it gets a tight window
  task dens(input int s);
    sample <= s;
    repeat (2000) @(posedge clock);
    o0 = ones;
    b0 = bits;
    repeat (8000) @(posedge clock);
    n = bits - b0;
    want = n * ((s >>> 8) + 32768) / 65536;
    tol = (s == 0) ? 2 : n / 8;
    cmp((ones - o0) inside {[want - tol : want + tol]}, 1'b1, "density");
  endtask
  initial begin
    void'($urandom(32'h75fbd6f3));
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      rstn <= 1'b0;
      strap <= k[0];
      half_ps <= 20'd62500;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      cmp(asleep, 1'b1, "asleep");
      run <= 1'b1;
      dens(0);
      dens($urandom_range(4194304) - 2097152);
      cmp(asleep, 1'b0, "awake");
      cmp(lp, 1'b0, "hq");
      half_ps <= 20'd651042;
      repeat (4000) @(posedge clock);
      cmp(lp, 1'b1, "lp");
      run <= 1'b0;
      repeat (1500) @(posedge clock);
      cmp(asleep, 1'b1, "sleep");
    end
    test_done;
  end
endmodule
